// *** hw/sdp_fifo.v ***
// small synchronous fifo with valid/ready on both sides.
// assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module sdp_fifo #(
  parameter WIDTH = 8,                   // word width
  parameter DEPTH = 16,                  // number of words
  parameter AW    = 4                    // address width, log2 depth
) (
  input  wire             clk,           // system clock
  input  wire             rst_b,         // async reset, active low
  input  wire             in_valid,      // write word offered
  output wire             in_ready,      // room for a word
  input  wire [WIDTH-1:0] in_data,       // write word
  output wire             out_valid,     // word available
  input  wire             out_ready,     // reader takes the word
  output wire [WIDTH-1:0] out_data       // head word
);

  localparam [AW:0] FULL_N = DEPTH[AW:0]; // count when full

  reg [WIDTH-1:0] mem [0:DEPTH-1];       // word storage
  reg [AW-1:0]    wr_ptr;                // write index
  reg [AW-1:0]    rd_ptr;                // read index
  reg [AW:0]      count;                 // words held
  wire            push;                  // write this cycle
  wire            pop;                   // read this cycle

  assign in_ready  = (count != FULL_N);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  // ----------------------------------------------------------------------
  // storage write, no reset needed on the data array
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // ----------------------------------------------------------------------
  // pointers and occupancy
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // sdp_fifo

`default_nettype wire

// *** hw/sdp_search.v ***
// search command engine: control byte handling, parameter list parsing,
// record framing and pattern comparison, status generation.
// assumes all inputs come from logic on SYS_CLK (no synchronisers) and
// that block data arrive as a byte stream with an end-of-block marker.
`timescale 1ns/1ps
`default_nettype none
`include "sdp_map.vh"

// Notes on behaviour
// - flag ignored unless link bit set
// - flag and link set request interrupt on success
// - linked success asks for next command
// - every command returns a status byte
// - parameter list accepted during data phase
// - bytes 0-3 give record size
// - bytes 4-7 give first record offset
// - later blocks searched from byte zero
// - bytes 8-B limit records examined
// - stop on record or block exhaustion
// - bytes C-D give argument length
// - all fields must match one record
// - entry is displacement, size, pattern
// - displacement measured from record start
// - compare exactly pattern size bytes
// - equal search needs data equal pattern
// - high search needs data at least pattern
// - low search needs data at most pattern
// - unlinked satisfied search gives condition met
module sdp_search (
  input  wire        SYS_CLK,          // system clock, 200 MHz
  input  wire        RST_B,            // async reset, active low
  input  wire        CMD_VALID,        // command offered
  input  wire [7:0]  CMD_OPCODE,       // command opcode
  input  wire [7:0]  CMD_CONTROL,      // control byte
  input  wire [15:0] CMD_BLOCKS,       // number of blocks
  output wire        CMD_READY,        // engine idle
  input  wire        PARM_VALID,       // parameter byte offered
  input  wire [7:0]  PARM_DATA,        // parameter byte
  output wire        PARM_READY,       // fifo has room
  input  wire        REC_VALID,        // block byte offered
  input  wire [7:0]  REC_DATA,         // block byte
  input  wire        REC_BLK_END,      // byte is last of its block
  output wire        REC_READY,        // block byte taken
  output reg         STATUS_VALID,     // status pulse
  output reg  [7:0]  STATUS_BYTE,      // status code
  output reg         FETCH_NEXT,       // fetch linked command pulse
  output reg         INTR_REQ,         // interrupt request pulse
  output reg  [15:0] MATCH_BLOCK,      // blocks passed before match
  output reg  [31:0] MATCH_OFFSET,     // record start in its block
  output wire [31:0] RECORD_SIZE       // parsed record size
);

  // ----------------------------------------------------------------------
  // states and declarations
  // ----------------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;      // waiting for a command
  localparam [2:0] S_HDR  = 3'h1;      // collecting fixed header
  localparam [2:0] S_ARG  = 3'h2;      // collecting argument
  localparam [2:0] S_SCAN = 3'h3;      // comparing block data
  localparam [2:0] S_DONE = 3'h4;      // issuing status

  reg  [2:0]   state;                  // engine state
  reg  [1:0]   mode;                   // 0 equal, 1 high, 2 low
  reg          link;                   // link bit of command
  reg          flag;                   // flag bit of command
  reg          sat;                    // search satisfied
  reg  [15:0]  blocks_left;            // blocks still to read
  reg  [15:0]  blk_done;               // blocks fully read
  reg  [111:0] hdr;                    // parameter header
  reg  [3:0]   hcnt;                   // header bytes taken
  reg  [7:0]   arg_mem [0:31];         // argument bytes
  reg  [15:0]  acnt;                   // argument bytes taken
  reg  [31:0]  rec_left;               // records still allowed
  reg  [31:0]  bpos;                   // byte position in block
  reg  [31:0]  rpos;                   // byte position in record
  reg          first_blk;              // still in first block
  reg  [6:0]   p;                      // current entry index
  reg  [1:0]   fcmp;                   // current field progress
  reg          rec_ok;                 // fields so far satisfied

  wire [7:0]   f_data;                 // fifo head byte
  wire         f_valid;                // fifo head valid
  wire         f_ready;                // engine takes head byte
  wire [31:0]  first_off;              // first record offset
  wire [31:0]  nrec;                   // record limit
  wire [15:0]  arglen;                 // argument length n
  wire [6:0]   arg_used;               // argument bytes stored
  wire [31:0]  disp;                   // entry displacement
  wire [15:0]  msz;                    // entry pattern size
  wire [17:0]  ent_end;                // index after entry
  wire         ent_valid;              // entry lies in argument
  wire         zero_ent;               // entry of zero size
  wire         skip;                   // byte before first record
  wire         take;                   // block byte accepted
  wire [31:0]  off;                    // position within field
  wire         in_fld;                 // byte inside current field
  wire [7:0]   pat;                    // pattern byte for compare
  wire [1:0]   cmp_n;                  // progress after this byte
  wire         fld_last;               // last byte of field
  wire         ok_n;                   // record still satisfied
  wire [6:0]   p_n;                    // entry index after byte
  wire         fields_done;            // no entry left to check
  wire         rec_end;                // last byte of record
  wire         blk_end;                // last byte of block
  wire         hit;                    // record satisfies search

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // argument byte at an index, zero past the stored argument so that
  // stale or unwritten bytes never decode as a further entry
  function [7:0] arg_at;
    input [6:0] idx;
    begin
      arg_at = (idx < arg_used) ? arg_mem[idx[4:0]] : 8'h00;
    end
  endfunction

  // lexicographic progress: first differing byte decides
  function [1:0] cmp_step;
    input [1:0] prev;
    input [7:0] d;
    input [7:0] q;
    begin
      if (prev != `SDP_CMP_EQ) begin
        cmp_step = prev;
      end else if (d > q) begin
        cmp_step = `SDP_CMP_GT;
      end else if (d < q) begin
        cmp_step = `SDP_CMP_LT;
      end else begin
        cmp_step = `SDP_CMP_EQ;
      end
    end
  endfunction

  // field verdict for the search kind
  function fld_ok;
    input [1:0] c;
    input [1:0] m;
    begin
      case (m)
        2'h1:    fld_ok = (c != `SDP_CMP_LT);
        2'h2:    fld_ok = (c != `SDP_CMP_GT);
        default: fld_ok = (c == `SDP_CMP_EQ);
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // parameter fifo
  // ----------------------------------------------------------------------
  sdp_fifo #(
    .WIDTH (8),
    .DEPTH (16),
    .AW    (4)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst_b     (RST_B),
    .in_valid  (PARM_VALID),
    .in_ready  (PARM_READY),
    .in_data   (PARM_DATA),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // ----------------------------------------------------------------------
  // header fields and entry decode
  // ----------------------------------------------------------------------
  assign RECORD_SIZE = hdr[`SDP_RSIZE_MSB:`SDP_RSIZE_LSB];
  assign first_off   = hdr[`SDP_FOFF_MSB:`SDP_FOFF_LSB];
  assign nrec        = hdr[`SDP_NREC_MSB:`SDP_NREC_LSB];
  assign arglen      = hdr[`SDP_ALEN_MSB:`SDP_ALEN_LSB];
  assign arg_used    = (arglen > {9'h000, `SDP_ARG_MAX}) ?
                       `SDP_ARG_MAX : arglen[6:0];
  assign CMD_READY   = (state == S_IDLE);
  // parameter bytes drain only while a list is being collected
  assign f_ready     = (state == S_HDR) |
                       ((state == S_ARG) & (acnt != arglen));

  // entry header: displacement then pattern size
  assign disp = {arg_at(p), arg_at(p + 7'h01),
                 arg_at(p + 7'h02), arg_at(p + 7'h03)};
  assign msz  = {arg_at(p + 7'h04), arg_at(p + 7'h05)};
  assign ent_end   = {11'h000, p} + {11'h000, `SDP_ENT_HDR} +
                     {2'h0, msz};
  assign ent_valid = (ent_end <= {11'h000, arg_used});
  assign zero_ent  = ent_valid & (msz == 16'h0000);

  // ----------------------------------------------------------------------
  // framing and comparison of one block byte
  // ----------------------------------------------------------------------
  assign skip      = first_blk & (bpos < first_off);
  assign REC_READY = (state == S_SCAN) & ~zero_ent;
  assign take      = REC_READY & REC_VALID;
  assign off       = rpos - disp;
  assign in_fld    = ent_valid & ~skip & (rpos >= disp) &
                     (off < {16'h0000, msz});
  assign pat       = arg_at(p + `SDP_ENT_HDR + off[6:0]);
  assign cmp_n     = in_fld ? cmp_step(fcmp, REC_DATA, pat) : fcmp;
  assign fld_last  = in_fld & (off == {16'h0000, msz} - 32'h1);
  assign ok_n      = rec_ok & (~fld_last | fld_ok(cmp_n, mode));
  assign p_n       = fld_last ? ent_end[6:0] : p;
  assign fields_done = ({11'h000, p_n} + {11'h000, `SDP_ENT_HDR}) >
                       {11'h000, arg_used};
  assign rec_end   = take & ~skip & (rpos == RECORD_SIZE - 32'h1);
  assign blk_end   = take & REC_BLK_END;
  assign hit       = rec_end & ok_n & fields_done;

  // ----------------------------------------------------------------------
  // argument storage, written as bytes arrive
  // ----------------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (f_valid & f_ready & (state == S_ARG) &
        (acnt < {9'h000, `SDP_ARG_MAX})) begin
      arg_mem[acnt[4:0]] <= f_data;
    end
  end

  // ----------------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------------
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state        <= S_IDLE;
      mode         <= 2'h0;
      link         <= 1'b0;
      flag         <= 1'b0;
      sat          <= 1'b0;
      blocks_left  <= 16'h0000;
      blk_done     <= 16'h0000;
      hdr          <= `SDP_HDR_RST;
      hcnt         <= 4'h0;
      acnt         <= 16'h0000;
      rec_left     <= 32'h0;
      bpos         <= 32'h0;
      rpos         <= 32'h0;
      first_blk    <= 1'b0;
      p            <= 7'h00;
      fcmp         <= `SDP_CMP_EQ;
      rec_ok       <= 1'b1;
      STATUS_VALID <= 1'b0;
      STATUS_BYTE  <= `SDP_ST_GOOD;
      FETCH_NEXT   <= 1'b0;
      INTR_REQ     <= 1'b0;
      MATCH_BLOCK  <= 16'h0000;
      MATCH_OFFSET <= 32'h0;
    end else begin
      // pulses last one cycle
      STATUS_VALID <= 1'b0;
      FETCH_NEXT   <= 1'b0;
      INTR_REQ     <= 1'b0;
      case (state)
        S_IDLE: begin
          if (CMD_VALID) begin
            // retry bit is taken with the byte and never looked at
            link <= CMD_CONTROL[`SDP_CTL_LINK];
            // flag only kept when link is set
            flag <= CMD_CONTROL[`SDP_CTL_FLAG] &
                    CMD_CONTROL[`SDP_CTL_LINK];
            blocks_left <= CMD_BLOCKS;
            blk_done    <= 16'h0000;
            hcnt        <= 4'h0;
            sat         <= 1'b0;
            case (CMD_OPCODE)
              `SDP_OP_EQUAL: begin
                mode  <= 2'h0;
                state <= S_HDR;
              end
              `SDP_OP_HIGH: begin
                mode  <= 2'h1;
                state <= S_HDR;
              end
              `SDP_OP_LOW: begin
                mode  <= 2'h2;
                state <= S_HDR;
              end
              default: begin
                // not a search: refuse with check condition
                STATUS_VALID <= 1'b1;
                STATUS_BYTE  <= `SDP_ST_CHECK;
              end
            endcase
          end
        end
        S_HDR: begin
          if (f_valid) begin
            hdr  <= {hdr[103:0], f_data};
            hcnt <= hcnt + 4'h1;
            if (hcnt == `SDP_HDR_BYTES - 4'h1) begin
              acnt  <= 16'h0000;
              state <= S_ARG;
            end
          end
        end
        S_ARG: begin
          if (acnt != arglen) begin
            if (f_valid) begin
              acnt <= acnt + 16'h0001;
            end
          end else begin
            rec_left  <= nrec;
            bpos      <= 32'h0;
            rpos      <= 32'h0;
            first_blk <= 1'b1;
            p         <= 7'h00;
            fcmp      <= `SDP_CMP_EQ;
            rec_ok    <= 1'b1;
            // nothing to search ends at once, unsatisfied
            if ((RECORD_SIZE == 32'h0) | (nrec == 32'h0) |
                (blocks_left == 16'h0000)) begin
              state <= S_DONE;
            end else begin
              state <= S_SCAN;
            end
          end
        end
        S_SCAN: begin
          if (zero_ent) begin
            // empty field is trivially met, step past it
            p <= ent_end[6:0];
          end else if (take) begin
            bpos <= blk_end ? 32'h0 : bpos + 32'h1;
            if (blk_end) begin
              first_blk   <= 1'b0;
              blocks_left <= blocks_left - 16'h0001;
              blk_done    <= blk_done + 16'h0001;
            end
            if (!skip) begin
              // a record cut by the block end is dropped
              if (rec_end | blk_end) begin
                rpos   <= 32'h0;
                p      <= 7'h00;
                fcmp   <= `SDP_CMP_EQ;
                rec_ok <= 1'b1;
              end else begin
                rpos   <= rpos + 32'h1;
                p      <= p_n;
                fcmp   <= fld_last ? `SDP_CMP_EQ : cmp_n;
                rec_ok <= ok_n;
              end
            end
            if (rec_end) begin
              rec_left <= rec_left - 32'h1;
            end
            if (hit) begin
              sat          <= 1'b1;
              MATCH_BLOCK  <= blk_done;
              MATCH_OFFSET <= bpos - rpos;
              state        <= S_DONE;
            end else if ((rec_end & (rec_left == 32'h1)) |
                         (blk_end & (blocks_left == 16'h0001))) begin
              state <= S_DONE;
            end
          end
        end
        S_DONE: begin
          STATUS_VALID <= 1'b1;
          if (sat & link) begin
            STATUS_BYTE <= `SDP_ST_ICMET;
            FETCH_NEXT  <= 1'b1;
            INTR_REQ    <= flag;
          end else if (sat) begin
            STATUS_BYTE <= `SDP_ST_CMET;
          end else begin
            STATUS_BYTE <= `SDP_ST_GOOD;
          end
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // sdp_search

`default_nettype wire

// *** pkg/sdp_map.vh ***
// constants for the search data parameter parser: opcodes, control
// byte bits, parameter header layout, status codes, sizes.
// assumes inclusion by bare name from each design file that needs it.
`ifndef SDP_MAP_VH
`define SDP_MAP_VH

// ----------------------------------------------------------------------
// search command opcodes
// ----------------------------------------------------------------------
`define SDP_OP_EQUAL     8'h31
`define SDP_OP_HIGH      8'h30
`define SDP_OP_LOW       8'h32

// ----------------------------------------------------------------------
// control byte bit positions
// ----------------------------------------------------------------------
`define SDP_CTL_LINK     0
`define SDP_CTL_FLAG     1
`define SDP_CTL_RETRY    7

// ----------------------------------------------------------------------
// parameter header: 14 bytes, shifted in msb first
// ----------------------------------------------------------------------
`define SDP_HDR_BYTES    4'hE
`define SDP_RSIZE_MSB    111
`define SDP_RSIZE_LSB    80
`define SDP_FOFF_MSB     79
`define SDP_FOFF_LSB     48
`define SDP_NREC_MSB     47
`define SDP_NREC_LSB     16
`define SDP_ALEN_MSB     15
`define SDP_ALEN_LSB     0
`define SDP_HDR_RST      112'h0

// ----------------------------------------------------------------------
// search argument entry layout and storage
// ----------------------------------------------------------------------
`define SDP_ENT_HDR      7'h06
`define SDP_ARG_MAX      7'h20

// ----------------------------------------------------------------------
// status byte codes
// ----------------------------------------------------------------------
`define SDP_ST_GOOD      8'h00
`define SDP_ST_CHECK     8'h02
`define SDP_ST_CMET      8'h04
`define SDP_ST_ICMET     8'h14

// ----------------------------------------------------------------------
// comparison progress codes
// ----------------------------------------------------------------------
`define SDP_CMP_EQ       2'h0
`define SDP_CMP_GT       2'h1
`define SDP_CMP_LT       2'h2

`endif

// *** testbench/sdp_init_model.sv ***
// initiator model: offers the search parameter list byte by byte.
// assumes a byte is taken on an edge with valid and ready high.
`timescale 1ns/1ps
`default_nettype none
module sdp_init_model (
  input  wire logic       clk,   // system clock
  input  wire logic       rst_b, // reset, active low
  output var  logic       valid, // parameter byte offered
  output var  logic [7:0] data,  // parameter byte
  input  wire logic       ready  // engine has room
);
  logic [7:0] q[$]; // bytes still to send
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // hold each byte until taken, pause at random, scramble idle data
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      valid <= 1'b0;
      data  <= 8'h00;
    end else if (valid && ready) begin
      void'(q.pop_front());
      valid <= 1'b0;
      data  <= ~data;
    end else if (!valid && q.size() != 0 && $urandom % 4 != 0) begin
      valid <= 1'b1;
      data  <= q[0];
    end else if (!valid) begin
      data <= ~data;
    end
  end
endmodule // sdp_init_model
`default_nettype wire

// *** testbench/sdp_search_props.sv ***
// assertions on the ports of the search engine.
// assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "sdp_map.vh"
module sdp_search_props (
  input wire logic       SYS_CLK,      // clock
  input wire logic       RST_B,        // reset, low
  input wire logic       CMD_VALID,    // command offered
  input wire logic [7:0] CMD_OPCODE,   // opcode
  input wire logic [7:0] CMD_CONTROL,  // control byte
  input wire logic       CMD_READY,    // idle
  input wire logic       REC_READY,    // block byte taken
  input wire logic       STATUS_VALID, // status pulse
  input wire logic [7:0] STATUS_BYTE,  // status code
  input wire logic       FETCH_NEXT,   // fetch pulse
  input wire logic       INTR_REQ      // interrupt pulse
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  logic [7:0] ctl; // control byte of the running command
  // ----------------------------------------------------------------
  // capture the control byte when a command is taken
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B)
    if (!RST_B) ctl <= 8'h00;
    else if (CMD_VALID && CMD_READY) ctl <= CMD_CONTROL;
  sequence take_s;
    CMD_VALID && CMD_READY;
  endsequence
  sequence bad_op_s;
    take_s ##0 !(CMD_OPCODE inside {8'h30, 8'h31, 8'h32});
  endsequence
  sequence search_op_s;
    take_s ##0 (CMD_OPCODE inside {8'h30, 8'h31, 8'h32});
  endsequence
  chk_busy_after_take: assert property (search_op_s |=> !CMD_READY)
    else $error("engine still idle after taking a command");
  chk_bad_opcode: assert property (bad_op_s |-> ##[1:2]
    STATUS_VALID && STATUS_BYTE == `SDP_ST_CHECK)
    else $error("refused opcode without check status");
  chk_status_pulse: assert property (STATUS_VALID &&
    !(CMD_VALID && CMD_READY) |=> !STATUS_VALID && CMD_READY)
    else $error("status not a single pulse");
  chk_fetch_linked: assert property (FETCH_NEXT |-> STATUS_VALID
    && ctl[0] && STATUS_BYTE == `SDP_ST_ICMET) else $error("bad fetch");
  chk_intr_flag: assert property (INTR_REQ |-> FETCH_NEXT && ctl[1])
    else $error("interrupt without link and flag");
  chk_linked_hit: assert property (STATUS_VALID &&
    STATUS_BYTE == `SDP_ST_ICMET |-> FETCH_NEXT && INTR_REQ == ctl[1])
    else $error("linked hit without fetch or interrupt");
  chk_cmet_unlinked: assert property (STATUS_VALID &&
    STATUS_BYTE == `SDP_ST_CMET |-> !ctl[0] && !FETCH_NEXT)
    else $error("condition met on a linked command");
  chk_idle_no_scan: assert property (CMD_READY |-> !REC_READY)
    else $error("block bytes taken while idle");
endmodule // sdp_search_props
bind sdp_search sdp_search_props u_props (.SYS_CLK, .RST_B, .CMD_VALID,
  .CMD_OPCODE, .CMD_CONTROL, .CMD_READY, .REC_READY, .STATUS_VALID,
  .STATUS_BYTE, .FETCH_NEXT, .INTR_REQ);
`default_nettype wire

// *** testbench/search_data_param_parser_tb.sv ***
// random searches on the search engine checked against a model.
// assumes the engine, its checker and the initiator model.
`timescale 1ns/1ps
`default_nettype none
`include "sdp_map.vh"
`define SDP_CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  error_cnt++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module search_data_param_parser_tb;
  logic        clk = 0, rst_b = 0, cmd_valid = 0, rec_valid = 0;
  logic        rec_end = 0;
  logic [7:0]  opc = 8'h00, ctl = 8'h00, rec_data = 8'h00;
  logic [15:0] nblk = 16'h0000;
  wire         pv, pr, cmd_ready, rec_ready, st_valid, fetch, intr;
  wire  [7:0]  pd, st_byte;
  wire  [15:0] m_blk;
  wire  [31:0] m_off, rsize;
  logic [7:0]  pat[$], dat[$]; // pattern and block bytes of one test
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  sdp_search u_dut (.SYS_CLK(clk), .RST_B(rst_b), .CMD_VALID(cmd_valid),
    .CMD_OPCODE(opc), .CMD_CONTROL(ctl), .CMD_BLOCKS(nblk),
    .CMD_READY(cmd_ready), .PARM_VALID(pv), .PARM_DATA(pd),
    .PARM_READY(pr), .REC_VALID(rec_valid), .REC_DATA(rec_data),
    .REC_BLK_END(rec_end), .REC_READY(rec_ready), .STATUS_VALID(st_valid),
    .STATUS_BYTE(st_byte), .FETCH_NEXT(fetch), .INTR_REQ(intr),
    .MATCH_BLOCK(m_blk), .MATCH_OFFSET(m_off), .RECORD_SIZE(rsize));
  sdp_init_model u_init (.clk(clk), .rst_b(rst_b), .valid(pv), .data(pd),
    .ready(pr));
  always #2.5 clk = ~clk;
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic push_n(input logic [31:0] v, input int nb);
    for (int i = nb - 1; i >= 0; i--) u_init.push(v[8*i +: 8]);
  endtask
  // first differing byte decides, as the search mode asks
  function automatic bit hit(input logic [7:0] op, input int base);
    int r;
    r = 0;
    foreach (pat[k])
      if (r == 0 && dat[base + k] != pat[k])
        r = dat[base + k] > pat[k] ? 1 : -1;
    return op == `SDP_OP_EQUAL ? r == 0 : op == `SDP_OP_HIGH ? r >= 0 : r <= 0;
  endfunction
  task automatic run_one(input logic [7:0] op);
    int bs, sz, off, nr, nb, d, m, c, hb, ho, i;
    bit sat, legal, tk;
    logic [7:0] cb, exp_st;
    legal = op inside {`SDP_OP_EQUAL, `SDP_OP_HIGH, `SDP_OP_LOW};
    pat.delete();
    dat.delete();
    bs = 8 + $urandom % 5;
    sz = 2 + $urandom % 4;
    off = $urandom % 4;
    nr = $urandom % 7;
    nb = $urandom % 4;
    m = ($urandom % 5 == 0) ? 0 : 1 + $urandom % 2;
    d = $urandom % (sz - m + 1);
    cb = {1'($urandom), 5'h00, 2'($urandom)};
    for (i = 0; i < m; i++) pat.push_back(8'($urandom % 3));
    for (i = 0; i < bs * nb; i++) dat.push_back(8'($urandom % 3));
    sat = 0;
    c = nr;
    for (int b = 0; b < nb && legal && !sat; b++)
      for (int p = b ? 0 : off; p + sz <= bs && c > 0 && !sat; p += sz) begin
        c--;
        sat = hit(op, b * bs + p + d);
        hb = b;
        ho = p;
      end
    exp_st = !legal ? `SDP_ST_CHECK : !sat ? `SDP_ST_GOOD :
             cb[0] ? `SDP_ST_ICMET : `SDP_ST_CMET;
    if (legal) begin
      push_n(sz, 4);
      push_n(off, 4);
      push_n(nr, 4);
      push_n(m ? 6 + m : 0, 2);
      if (m) begin
        push_n(d, 4);
        push_n(m, 2);
        foreach (pat[k]) u_init.push(pat[k]);
      end
    end
    repeat (80) @(posedge clk);
    if (legal && m) `SDP_CHK("parm_ready", 1'b0, pr)
    opc <= op;
    ctl <= cb;
    nblk <= 16'(nb);
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    i = 0;
    for (int t = 0; t < 3000; t++) begin
      @(posedge clk);
      tk = rec_valid && rec_ready;
      if (st_valid) break;
      i += tk;
      rec_valid <= i < dat.size() && ((rec_valid && !tk) || $urandom % 4 != 0);
      rec_data <= i < dat.size() ? dat[i] : ~rec_data;
      rec_end <= i % bs == bs - 1;
    end
    rec_valid <= 1'b0;
    `SDP_CHK("status_seen", 1'b1, st_valid)
    `SDP_CHK("status", exp_st, st_byte)
    `SDP_CHK("fetch", cb[0] && sat, fetch)
    `SDP_CHK("intr", cb[0] && cb[1] && sat, intr)
    if (sat) `SDP_CHK("block", 16'(hb), m_blk)
    if (sat) `SDP_CHK("offset", 32'(ho), m_off)
    if (legal) `SDP_CHK("size", 32'(sz), rsize)
  endtask
  initial begin
    void'($urandom(46));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      run_one(k % 13 == 12 ? 8'h28 : 8'h30 + 8'(k % 3));
      $display("test %0d done", k);
    end
    end_of_test();
  end
endmodule // search_data_param_parser_tb
`default_nettype wire
